// file: common/thermal_pkg.sv
// constants shared by the thermal protection supervisor and its helpers
// assumes one 20 MHz system clock and a synchronous active-high reset
package thermal_pkg;
  localparam int unsigned CLK_HZ             = 20000000;
  // fail-safe dwell after chip shutdown, in milliseconds
  localparam int unsigned DWELL_TIME_MS      = 1000;
  localparam longint unsigned DWELL_CYCLES_L =
    (longint'(DWELL_TIME_MS) * longint'(CLK_HZ)) / 64'd1000;
  localparam int unsigned DWELL_CYCLES       = int'(DWELL_CYCLES_L);
  localparam int unsigned DWELL_W            = 25;
  localparam int unsigned LIN_CHANNELS       = 2;
  localparam int unsigned FAULT_W            = 2;
  localparam logic [1:0]  FAULT_NONE         = 2'h0;
  localparam logic [1:0]  FAULT_OVERTEMP     = 2'h1;
  localparam int unsigned AUX_EN_W           = 2;
  localparam logic [1:0]  AUX_EN_RESET       = 2'h0;
  // chip operating modes as seen by this block
  typedef enum logic [2:0] {
    MODE_INIT      = 3'h0,
    MODE_NORMAL    = 3'h1,
    MODE_STOP      = 3'h2,
    MODE_SLEEP     = 3'h3,
    MODE_RESTART   = 3'h4,
    MODE_FAILSAFE  = 3'h5
  } chip_mode_t;
endpackage

// file: logic/thermal_sync.sv
// three-stage synchroniser for asynchronous comparator levels
// assumes inputs come from analog comparators outside the clock domain
module thermal_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  initial begin
    if (WIDTH < 1) $error("thermal_sync needs WIDTH >= 1");
  end

  // level only counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_reg   <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      sync_out   <= '0;
    end else if (clk_en) begin
      meta_reg   <= async_in;
      stage2_reg <= meta_reg;
      stage3_reg <= stage2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          sync_out[i] <= stage3_reg[i];
        end
      end
    end
  end
endmodule

// file: logic/dwell_timer.sv
// one-shot down counter for the fail-safe dwell after chip shutdown
// assumes start is a single-cycle pulse on the system clock
module dwell_timer #(
  parameter int unsigned CYCLES = thermal_pkg::DWELL_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic start,
  output logic      busy
);
  logic [thermal_pkg::DWELL_W-1:0] count_reg;

  initial begin
    if (CYCLES < 1 || CYCLES >= (1 << thermal_pkg::DWELL_W))
      $error("dwell_timer CYCLES out of range");
  end

  // a new start restarts the full dwell
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_reg <= '0;
      busy      <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        count_reg <= thermal_pkg::DWELL_W'(CYCLES - 1);
        busy      <= 1'b1;
      end else if (count_reg != '0) begin
        count_reg <= count_reg - 1'b1;
      end else begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// file: logic/thermal_protection_manager.sv
// thermal protection supervisor: block shutdown, buck prewarning, chip shutdown
// assumes comparator levels are asynchronous and all other inputs are on sys_clk

module thermal_protection_manager #(
  parameter int unsigned DWELL_CYCLES = thermal_pkg::DWELL_CYCLES,
  parameter int unsigned LIN_CHANNELS = thermal_pkg::LIN_CHANNELS
) (
  input  wire logic                                sys_clk,
  input  wire logic                                reset,
  input  wire logic                                clk_en,
  input  wire thermal_pkg::chip_mode_t             chip_mode,
  input  wire logic                                watchdog_active,
  input  wire logic                                buck_on,
  input  wire logic                                buck_pwm,
  input  wire logic                                aux_ot_async,
  input  wire logic                                can_ot_async,
  input  wire logic [LIN_CHANNELS-1:0]             lin_ot_async,
  input  wire logic                                prewarn_async,
  input  wire logic                                chip_ot_async,
  input  wire logic                                aux_enable_write,
  input  wire logic [thermal_pkg::AUX_EN_W-1:0]    aux_enable_wdata,
  input  wire logic                                can_enable,
  input  wire logic [LIN_CHANNELS-1:0]             lin_enable,
  input  wire logic                                clear_block_flag,
  input  wire logic                                clear_aux_flag,
  input  wire logic                                clear_can_fault,
  input  wire logic [LIN_CHANNELS-1:0]             clear_lin_fault,
  input  wire logic                                clear_prewarn,
  input  wire logic                                clear_chip_flag,
  output logic [thermal_pkg::AUX_EN_W-1:0]         aux_supply_enable_bits,
  output logic                                     aux_supply_output,
  output logic                                     can_tx_enable,
  output logic [LIN_CHANNELS-1:0]                  lin_tx_enable,
  output logic                                     block_thermal_shutdown_flag,
  output logic                                     aux_supply_overtemp_flag,
  output logic [thermal_pkg::FAULT_W-1:0]          can_fault_field,
  output logic [LIN_CHANNELS*thermal_pkg::FAULT_W-1:0] linbus_fault_field,
  output logic                                     buck_temp_prewarn_flag,
  output logic                                     chip_thermal_shutdown_flag,
  output logic                                     failsafe_request,
  output logic                                     failsafe_hold,
  output logic                                     wake_can_enable,
  output logic [LIN_CHANNELS-1:0]                  wake_lin_enable,
  output logic                                     wake_input_pin_enable,
  output logic                                     failsafe_outputs_active
);
  localparam int unsigned NSYNC = LIN_CHANNELS + 4;

  initial begin
    if (LIN_CHANNELS < 1 || LIN_CHANNELS > 4)
      $error("LIN_CHANNELS must lie between 1 and 4");
  end

  logic [NSYNC-1:0]        sync_in;
  logic [NSYNC-1:0]        sync_out;
  logic                    aux_ot;
  logic                    can_ot;
  logic [LIN_CHANNELS-1:0] lin_ot;
  logic                    prewarn_ot;
  logic                    chip_ot;

  assign sync_in = {chip_ot_async, prewarn_async, lin_ot_async, can_ot_async, aux_ot_async};

  // comparators pass three stages before use
  thermal_sync #(
    .WIDTH (NSYNC)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .async_in (sync_in),
    .sync_out (sync_out)
  );

  assign aux_ot     = sync_out[0];
  assign can_ot     = sync_out[1];
  assign lin_ot     = sync_out[LIN_CHANNELS+1:2];
  assign prewarn_ot = sync_out[LIN_CHANNELS+2];
  assign chip_ot    = sync_out[LIN_CHANNELS+3];

  // qualified events
  logic                    aux_prot_mode;
  logic                    aux_event;
  logic                    can_event;
  logic [LIN_CHANNELS-1:0] lin_event;
  logic                    prewarn_event;
  logic                    chip_event;
  logic                    chip_event_d_reg;
  logic                    chip_rise;
  logic                    dwell_busy;

  // aux protection limited to normal, or stop with watchdog running
  assign aux_prot_mode = (chip_mode == thermal_pkg::MODE_NORMAL) ||
                         ((chip_mode == thermal_pkg::MODE_STOP) && watchdog_active);
  assign aux_event     = aux_ot && aux_supply_output && aux_prot_mode;
  assign can_event     = can_ot && can_enable;
  assign lin_event     = lin_ot & lin_enable;
  assign prewarn_event = prewarn_ot && buck_on;
  assign chip_event    = chip_ot && buck_on && buck_pwm;
  assign chip_rise     = chip_event && !chip_event_d_reg;

  // aux supply: stays off until software writes the enables again
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aux_supply_enable_bits <= thermal_pkg::AUX_EN_RESET;
      aux_supply_output      <= 1'b0;
    end else if (clk_en) begin
      if (aux_event) begin
        aux_supply_enable_bits <= '0;
        aux_supply_output      <= 1'b0;
      end else if (aux_enable_write) begin
        aux_supply_enable_bits <= aux_enable_wdata;
        aux_supply_output      <= |aux_enable_wdata;
      end
    end
  end

  // transceivers re-enable themselves, unlike the aux supply
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      can_tx_enable <= 1'b0;
      lin_tx_enable <= '0;
    end else if (clk_en) begin
      can_tx_enable <= can_enable && !can_ot;
      lin_tx_enable <= lin_enable & ~lin_ot;
    end
  end

  // block shutdown flag; set beats clear, clear needs condition gone
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      block_thermal_shutdown_flag <= 1'b0;
    end else if (clk_en) begin
      if (aux_event || can_event || (|lin_event)) begin
        block_thermal_shutdown_flag <= 1'b1;
      end else if (clear_block_flag && !aux_ot && !can_ot && !(|lin_ot)) begin
        block_thermal_shutdown_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aux_supply_overtemp_flag <= 1'b0;
    end else if (clk_en) begin
      if (aux_event) begin
        aux_supply_overtemp_flag <= 1'b1;
      end else if (clear_aux_flag && !aux_ot) begin
        aux_supply_overtemp_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      can_fault_field <= thermal_pkg::FAULT_NONE;
    end else if (clk_en) begin
      if (can_event) begin
        can_fault_field <= thermal_pkg::FAULT_OVERTEMP;
      end else if (clear_can_fault && !can_ot) begin
        can_fault_field <= thermal_pkg::FAULT_NONE;
      end
    end
  end

  // one fault field per LIN channel
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      linbus_fault_field <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < LIN_CHANNELS; i++) begin
        if (lin_event[i]) begin
          linbus_fault_field[i*thermal_pkg::FAULT_W +: thermal_pkg::FAULT_W] <=
            thermal_pkg::FAULT_OVERTEMP;
        end else if (clear_lin_fault[i] && !lin_ot[i]) begin
          linbus_fault_field[i*thermal_pkg::FAULT_W +: thermal_pkg::FAULT_W] <=
            thermal_pkg::FAULT_NONE;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      buck_temp_prewarn_flag <= 1'b0;
    end else if (clk_en) begin
      if (prewarn_event) begin
        buck_temp_prewarn_flag <= 1'b1;
      end else if (clear_prewarn && !prewarn_ot) begin
        buck_temp_prewarn_flag <= 1'b0;
      end
    end
  end

  // chip flag clear only accepted in normal mode
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      chip_thermal_shutdown_flag <= 1'b0;
      chip_event_d_reg           <= 1'b0;
    end else if (clk_en) begin
      chip_event_d_reg <= chip_event;
      if (chip_event) begin
        chip_thermal_shutdown_flag <= 1'b1;
      end else if (clear_chip_flag && !chip_ot &&
                   (chip_mode == thermal_pkg::MODE_NORMAL)) begin
        chip_thermal_shutdown_flag <= 1'b0;
      end
    end
  end

  // dwell restarts on each fresh chip event
  dwell_timer #(
    .CYCLES (DWELL_CYCLES)
  ) u_dwell (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .start   (chip_rise),
    .busy    (dwell_busy)
  );

  // fail-safe request pulses on entry; hold forbids leaving during dwell
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      failsafe_request <= 1'b0;
      failsafe_hold    <= 1'b0;
    end else if (clk_en) begin
      failsafe_request <= chip_rise;
      failsafe_hold    <= chip_rise || dwell_busy;
    end
  end

  // default wake sources and fail-safe outputs latch until normal mode with the dwell ended
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wake_can_enable         <= 1'b0;
      wake_lin_enable         <= '0;
      wake_input_pin_enable   <= 1'b0;
      failsafe_outputs_active <= 1'b0;
    end else if (clk_en) begin
      if (chip_rise) begin
        wake_can_enable         <= 1'b1;
        wake_lin_enable         <= '1;
        wake_input_pin_enable   <= 1'b1;
        failsafe_outputs_active <= 1'b1;
      end else if (chip_mode == thermal_pkg::MODE_NORMAL && !dwell_busy) begin
        wake_can_enable         <= 1'b0;
        wake_lin_enable         <= '0;
        wake_input_pin_enable   <= 1'b0;
        failsafe_outputs_active <= 1'b0;
      end
    end
  end
endmodule

// file: sim/thermal_protection_manager_assertions.sv
// port-level checker for the thermal protection supervisor
// assumes one clock domain; clk_en only dropped briefly while nothing is pending
module thermal_protection_manager_checker #(
  parameter int unsigned DWELL_CYCLES = 20,
  parameter int unsigned LIN_CHANNELS = 2
) (
  input wire logic                          sys_clk,
  input wire logic                          reset,
  input wire logic                          can_enable,
  input wire logic                          clear_prewarn,
  input wire logic                          clear_aux_flag,
  input wire logic                          clear_chip_flag,
  input wire thermal_pkg::chip_mode_t       chip_mode,
  input wire logic [1:0]                    aux_supply_enable_bits,
  input wire logic                          aux_supply_output,
  input wire logic                          can_tx_enable,
  input wire logic [LIN_CHANNELS-1:0]       lin_tx_enable,
  input wire logic [1:0]                    can_fault_field,
  input wire logic [LIN_CHANNELS*2-1:0]     linbus_fault_field,
  input wire logic                          block_thermal_shutdown_flag,
  input wire logic                          aux_supply_overtemp_flag,
  input wire logic                          buck_temp_prewarn_flag,
  input wire logic                          chip_thermal_shutdown_flag,
  input wire logic                          failsafe_request,
  input wire logic                          failsafe_hold,
  input wire logic                          wake_can_enable,
  input wire logic [LIN_CHANNELS-1:0]       wake_lin_enable,
  input wire logic                          wake_input_pin_enable,
  input wire logic                          failsafe_outputs_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] hold_cnt_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // cycles spent in the dwell, a repetition would be far too long to unroll
  always_ff @(posedge sys_clk) begin
    if (reset || !failsafe_hold) hold_cnt_reg <= 32'h0;
    else hold_cnt_reg <= hold_cnt_reg + 32'h1;
  end
  a_can_tx_gate: assert property (can_tx_enable |-> $past(can_enable))
    else $error("can transmitter on while block off");
  a_can_fault_off: assert property ($rose(can_fault_field[0]) |-> !can_tx_enable
    && can_fault_field == thermal_pkg::FAULT_OVERTEMP) else $error("can fault without tx off");
  a_lin_fault_off: assert property ($rose(linbus_fault_field[0]) |->
    !lin_tx_enable[0] && !linbus_fault_field[1]) else $error("lin fault without tx off");
  a_block_flag_set: assert property ($rose(can_fault_field[0]) |->
    block_thermal_shutdown_flag) else $error("block flag missing on can fault");
  a_aux_supply_off: assert property ($rose(aux_supply_overtemp_flag) |-> !aux_supply_output
    && aux_supply_enable_bits == 2'h0) else $error("aux supply left on");
  a_aux_flag_held: assert property ($fell(aux_supply_overtemp_flag) |->
    $past(clear_aux_flag)) else $error("aux flag cleared itself");
  a_prewarn_held: assert property ($fell(buck_temp_prewarn_flag) |->
    $past(clear_prewarn)) else $error("prewarn flag cleared itself");
  a_chip_entry_all: assert property ($rose(chip_thermal_shutdown_flag) |-> failsafe_request
    && failsafe_hold && wake_can_enable && (&wake_lin_enable) && wake_input_pin_enable
    && failsafe_outputs_active) else $error("chip shutdown entry incomplete");
  a_request_pulse: assert property (failsafe_request |=> !failsafe_request)
    else $error("fail-safe request longer than one cycle");
  a_dwell_min_len: assert property ($fell(failsafe_hold) |->
    hold_cnt_reg >= DWELL_CYCLES) else $error("fail-safe dwell too short");
  a_chip_clear_mode: assert property ($fell(chip_thermal_shutdown_flag) |->
    $past(clear_chip_flag) && $past(chip_mode) == thermal_pkg::MODE_NORMAL)
    else $error("chip flag cleared outside normal mode");
  c_chip_entry: cover property ($rose(failsafe_hold));
  c_can_fault: cover property ($rose(can_fault_field[0]));
  c_aux_event: cover property ($rose(aux_supply_overtemp_flag));
endmodule

bind thermal_protection_manager thermal_protection_manager_checker #(
  .DWELL_CYCLES(DWELL_CYCLES), .LIN_CHANNELS(LIN_CHANNELS)) checker_i (
  .sys_clk(sys_clk), .reset(reset), .can_enable(can_enable), .clear_prewarn(clear_prewarn),
  .clear_aux_flag(clear_aux_flag), .clear_chip_flag(clear_chip_flag), .chip_mode(chip_mode),
  .aux_supply_enable_bits(aux_supply_enable_bits), .aux_supply_output(aux_supply_output),
  .can_tx_enable(can_tx_enable), .lin_tx_enable(lin_tx_enable),
  .can_fault_field(can_fault_field), .linbus_fault_field(linbus_fault_field),
  .block_thermal_shutdown_flag(block_thermal_shutdown_flag),
  .aux_supply_overtemp_flag(aux_supply_overtemp_flag),
  .buck_temp_prewarn_flag(buck_temp_prewarn_flag),
  .chip_thermal_shutdown_flag(chip_thermal_shutdown_flag),
  .failsafe_request(failsafe_request), .failsafe_hold(failsafe_hold),
  .wake_can_enable(wake_can_enable), .wake_lin_enable(wake_lin_enable),
  .wake_input_pin_enable(wake_input_pin_enable),
  .failsafe_outputs_active(failsafe_outputs_active));

// file: sim/thermal_protection_manager_bench.sv
// self-checking bench for the thermal protection supervisor
// assumes a short dwell parameter; inputs change 1 ns after the rising edge
module thermal_protection_manager_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DW = 20;
  thermal_pkg::chip_mode_t mode = thermal_pkg::MODE_NORMAL;
  thermal_pkg::chip_mode_t am [5] = '{thermal_pkg::MODE_NORMAL, thermal_pkg::MODE_STOP,
    thermal_pkg::MODE_STOP, thermal_pkg::MODE_SLEEP, thermal_pkg::MODE_NORMAL};
  logic [1:0] adat [5] = '{2'h3, 2'h1, 2'h2, 2'h3, 2'h0};
  logic       awdg [5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
  logic       aexp [5] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
  logic sys_clk = 1'h0, reset = 1'h1, wd = 1'h0, bon = 1'h0, bpwm = 1'h0, aux_ot = 1'h0;
  logic can_ot = 1'h0, pw_ot = 1'h0, chip_ot = 1'h0, aux_wr = 1'h0, can_en = 1'h0;
  logic c_blk = 1'h0, c_aux = 1'h0, c_can = 1'h0, c_pw = 1'h0, c_chip = 1'h0, ce = 1'h1;
  logic [1:0] lin_ot = 2'h0, lin_en = 2'h0, c_lin = 2'h0, aux_wd = 2'h0;
  logic [1:0] aux_bits, can_flt, lin_tx, wk_lin;
  logic [3:0] lin_flt;
  logic       aux_out, can_tx, blk_f, aux_f, pw_f, chip_f, fs_req, fs_hold, wk_can, wk_pin, fs_out;
  int         err_count = 0, tests_run = 0, cycles = 0;

  thermal_protection_manager #(.DWELL_CYCLES(DW), .LIN_CHANNELS(2)) thermal_protection_manager_i (
    .sys_clk(sys_clk), .reset(reset), .clk_en(ce), .chip_mode(mode), .watchdog_active(wd),
    .buck_on(bon), .buck_pwm(bpwm), .aux_ot_async(aux_ot), .can_ot_async(can_ot),
    .lin_ot_async(lin_ot), .prewarn_async(pw_ot), .chip_ot_async(chip_ot),
    .aux_enable_write(aux_wr), .aux_enable_wdata(aux_wd), .can_enable(can_en),
    .lin_enable(lin_en), .clear_block_flag(c_blk), .clear_aux_flag(c_aux),
    .clear_can_fault(c_can), .clear_lin_fault(c_lin), .clear_prewarn(c_pw),
    .clear_chip_flag(c_chip), .aux_supply_enable_bits(aux_bits), .aux_supply_output(aux_out),
    .can_tx_enable(can_tx), .lin_tx_enable(lin_tx), .block_thermal_shutdown_flag(blk_f),
    .aux_supply_overtemp_flag(aux_f), .can_fault_field(can_flt), .linbus_fault_field(lin_flt),
    .buck_temp_prewarn_flag(pw_f), .chip_thermal_shutdown_flag(chip_f),
    .failsafe_request(fs_req), .failsafe_hold(fs_hold), .wake_can_enable(wk_can),
    .wake_lin_enable(wk_lin), .wake_input_pin_enable(wk_pin),
    .failsafe_outputs_active(fs_out));

  always #25 sys_clk = ~sys_clk;

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // whole run needs well under 1000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    step(20);
    reset = 1'h0;
    step(1);
    chk("chip_f", 8'h0, chip_f);
    can_en = 1'h1;
    lin_en = 2'h3;
    step(2);
    ce = 1'h0;
    can_ot = 1'h1;
    step(6);
    chk("can_tx", 8'h1, can_tx);
    chk("can_flt", 8'h0, can_flt);
    ce = 1'h1;
    step(6);
    chk("can_tx", 8'h0, can_tx);
    chk("can_flt", 8'h1, can_flt);
    chk("blk_f", 8'h1, blk_f);
    chk("lin_tx", 8'h3, lin_tx);
    c_can = 1'h1;
    step(1);
    c_can = 1'h0;
    chk("can_flt", 8'h1, can_flt);
    can_ot = 1'h0;
    step(6);
    chk("can_tx", 8'h1, can_tx);
    chk("can_flt", 8'h1, can_flt);
    c_can = 1'h1;
    c_blk = 1'h1;
    step(1);
    {c_can, c_blk} = 2'h0;
    chk("can_flt", 8'h0, can_flt);
    chk("blk_f", 8'h0, blk_f);
    for (int i = 0; i < 2; i++) begin
      lin_ot = 2'h1 << i;
      step(6);
      chk("lin_tx", lin_ot ^ 2'h3, lin_tx);
      chk("lin_flt", 4'h1 << (2 * i), lin_flt);
      lin_ot = 2'h0;
      step(6);
      chk("lin_tx", 8'h3, lin_tx);
      c_lin = 2'h3;
      c_blk = 1'h1;
      step(1);
      {c_lin, c_blk} = 3'h0;
      chk("lin_flt", 8'h0, lin_flt);
    end
    can_en = 1'h0;
    can_ot = 1'h1;
    step(6);
    chk("blk_f", 8'h0, blk_f);
    can_ot = 1'h0;
    for (int i = 0; i < 5; i++) begin
      mode = am[i];
      wd = awdg[i];
      aux_wd = adat[i];
      aux_wr = 1'h1;
      step(1);
      aux_wr = 1'h0;
      step(1);
      chk("aux_out", |adat[i], aux_out);
      aux_ot = 1'h1;
      step(6);
      chk("aux_f", aexp[i], aux_f);
      chk("aux_bits", aexp[i] ? 2'h0 : adat[i], aux_bits);
      chk("blk_f", aexp[i], blk_f);
      aux_ot = 1'h0;
      step(6);
      {c_aux, c_blk} = 2'h3;
      step(1);
      {c_aux, c_blk} = 2'h0;
      chk("aux_f", 8'h0, aux_f);
      chk("aux_out", !aexp[i] && |adat[i], aux_out);
    end
    mode = thermal_pkg::MODE_NORMAL;
    pw_ot = 1'h1;
    step(6);
    chk("pw_f", 8'h0, pw_f);
    pw_ot = 1'h0;
    step(6);
    chk("pw_f", 8'h0, pw_f);
    bon = 1'h1;
    pw_ot = 1'h1;
    step(6);
    chk("pw_f", 8'h1, pw_f);
    c_pw = 1'h1;
    step(1);
    c_pw = 1'h0;
    chk("pw_f", 8'h1, pw_f);
    pw_ot = 1'h0;
    step(6);
    c_pw = 1'h1;
    step(1);
    c_pw = 1'h0;
    chk("pw_f", 8'h0, pw_f);
    chip_ot = 1'h1;
    step(6);
    chk("chip_f", 8'h0, chip_f);
    {chip_ot, bon, bpwm} = 3'h1;
    step(6);
    chip_ot = 1'h1;
    step(6);
    chk("chip_f", 8'h0, chip_f);
    chip_ot = 1'h0;
    step(6);
    bon = 1'h1;
    chip_ot = 1'h1;
    step(5);
    chk("fs_req", 8'h1, fs_req);
    step(1);
    chk("fs_req", 8'h0, fs_req);
    chk("chip_f", 8'h1, chip_f);
    chk("fs_hold", 8'h1, fs_hold);
    chk("wake", 8'h1F, {wk_can, wk_lin, wk_pin, fs_out});
    mode = thermal_pkg::MODE_STOP;
    chip_ot = 1'h0;
    step(DW - 4);
    chk("fs_hold", 8'h1, fs_hold);
    step(10);
    chk("fs_hold", 8'h0, fs_hold);
    c_chip = 1'h1;
    step(1);
    c_chip = 1'h0;
    chk("chip_f", 8'h1, chip_f);
    mode = thermal_pkg::MODE_NORMAL;
    step(2);
    c_chip = 1'h1;
    step(1);
    c_chip = 1'h0;
    chk("chip_f", 8'h0, chip_f);
    end_of_test();
  end
endmodule
